// file: hdl/ddpf_pkg.sv
// Package: register map, fields, reset values and timing for the DIO DMA pacer block
package ddpf_pkg;
  // Register byte offsets
  localparam logic [7:0] DDPF_CTRL_OFS   = 8'h00;
  localparam logic [7:0] DDPF_STAT_OFS   = 8'h04;
  localparam logic [7:0] DDPF_IN_DIV_OFS = 8'h08;
  localparam logic [7:0] DDPF_OUT_DIV_OFS = 8'h0C;
  localparam logic [7:0] DDPF_AUX_DIV_OFS = 8'h10;
  localparam logic [7:0] DDPF_IN_ADDR_OFS = 8'h14;
  localparam logic [7:0] DDPF_IN_CNT_OFS  = 8'h18;
  localparam logic [7:0] DDPF_OUT_ADDR_OFS = 8'h1C;
  localparam logic [7:0] DDPF_OUT_CNT_OFS  = 8'h20;
  localparam logic [7:0] DDPF_IN_LEFT_OFS  = 8'h24;
  localparam logic [7:0] DDPF_OUT_LEFT_OFS = 8'h28;
  // Control fields (write 1 to the command bits; they self clear)
  localparam int DDPF_C_IN_START   = 0;
  localparam int DDPF_C_IN_ABORT   = 1;
  localparam int DDPF_C_OUT_START  = 2;
  localparam int DDPF_C_OUT_ABORT  = 3;
  localparam int DDPF_C_CLR_FIFO   = 4;
  localparam int DDPF_C_STOP_OPT   = 5;
  localparam int DDPF_C_IN_CHAIN   = 6;
  localparam int DDPF_C_OUT_CHAIN  = 7;
  localparam int DDPF_C_PATTERN    = 8;
  localparam int DDPF_C_CFG_LSB    = 9;
  // Status fields
  localparam int DDPF_S_IN_BUSY    = 0;
  localparam int DDPF_S_OUT_BUSY   = 1;
  localparam int DDPF_S_OVERRUN    = 2;
  localparam int DDPF_S_UNDERRUN   = 3;
  localparam int DDPF_S_SAMPLING   = 4;
  // Port configurations
  localparam logic [1:0] DDPF_OUT_32BIT_CONFIG  = 2'h0;
  localparam logic [1:0] DDPF_IN16_OUT8_CONFIG  = 2'h1;
  localparam logic [1:0] DDPF_IN8_OUT8_CONFIG   = 2'h2;
  // Reset values and limits
  localparam logic [15:0] DDPF_DIV_RST  = 16'h000A;
  localparam logic [15:0] DDPF_DIV_MIN  = 16'h0002;
  localparam logic [21:0] DDPF_CNT_MAX  = 22'h200000;
  localparam int          DDPF_FIFO_DEPTH = 16;
  localparam int          DDPF_FIFO_AW    = 4;
  localparam int          DDPF_DSCR_WORDS = 4;
  // Pacer base: timer base of 10 MHz derived from the 20 MHz clock
  localparam int          DDPF_MCLK_HZ  = 20000000;
  localparam int          DDPF_BASE_HZ  = 10000000;
  localparam logic [3:0]  DDPF_BASE_DIV = 4'(DDPF_MCLK_HZ / DDPF_BASE_HZ);
endpackage

// file: hdl/ddpf_top.sv
// DIO DMA engine: paced input and output FIFOs, bus master, pacers, APB registers
//
// Behaviour
// - Sampled input words wait in a FIFO; moved to memory only when granted
// - Input sample into full FIFO sets overrun flag, reads 1, else 0
// - Output DMA words leave the output FIFO onto the output port
// - Output word needed with empty FIFO sets underrun flag, reads 1, else 0
// - Input pacer ticks at 10 MHz divided by input divisor
// - Output pacer ticks at 10 MHz divided by output divisor
// - Contiguous mode length counts double-words, at most 2^21
// - Chained mode length zero; amount comes from linked descriptor nodes
// - Output DMA runs until count done or aborted
// - Status reads 0 when done, 1 while in progress
// - Abort stops active input or output DMA at once
// - Pattern generation replays output buffer until stopped
// - Output sample is 4 bytes in 32-bit config, else 1 byte
// - Port width used for packing is 8, 16 or 32 bits
// - Clear-FIFO option at input start discards held input data
// - Stop-sampling option ends sampling when input DMA completes
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/10ps
module ddpf_top
  import ddpf_pkg::*;
(
  input  wire logic        I_MCLK,
  input  wire logic        I_RST_B,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  output logic             O_MREQ,
  input  wire logic        I_MGNT,
  output logic      [31:0] O_MADDR,
  output logic             O_MWRITE,
  output logic      [31:0] O_MWDATA,
  input  wire logic [31:0] I_MRDATA,
  input  wire logic        I_MACK,
  input  wire logic [31:0] I_DIN,
  output logic      [31:0] O_DOUT,
  output logic             O_AUX_TICK
);

  typedef enum logic [2:0] {ST_IDLE, ST_IN_WR, ST_OUT_RD, ST_DSCR} ddpf_bus_e;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [15:0] div_r [3], div_nxt [3];
  logic [15:0] pcnt_r [3], pcnt_nxt [3];
  logic [2:0]  tick;
  logic [3:0]  base_r, base_nxt;
  logic [31:0] in_addr_r, in_addr_nxt, out_addr_r, out_addr_nxt;
  logic [21:0] in_cnt_r, out_cnt_r;
  logic [21:0] in_left_r, in_left_nxt, out_left_r, out_left_nxt;
  logic [31:0] out_base_r, out_base_nxt;
  logic        in_busy_r, in_busy_nxt, out_busy_r, out_busy_nxt, samp_r, samp_nxt;
  logic        ovr_r, ovr_nxt, und_r, und_nxt;
  logic [31:0] ifq_r [DDPF_FIFO_DEPTH], ofq_r [DDPF_FIFO_DEPTH];
  logic [DDPF_FIFO_AW:0] iw_r, iw_nxt, ir_r, ir_nxt, ow_r, ow_nxt, or_r, or_nxt;
  logic [31:0] dout_r, dout_nxt, samp_word;
  logic [1:0]  lane_r, lane_nxt, ilane_r, ilane_nxt;
  logic [31:0] ipack_r, ipack_nxt;
  logic [1:0]  dcnt_r, dcnt_nxt;
  logic        dsc_in_r, dsc_in_nxt;
  logic [31:0] dnext_r, dnext_nxt;
  ddpf_bus_e   st_r, st_nxt;
  logic [31:0] prdata_nxt;
  logic        in_full, in_empty, out_full, out_empty, acc, wr, in_push, out_pop, opush;
  logic        in_start, in_abort, out_start, out_abort, in_done, out_done;
  logic [1:0]  cfg;

  // Last sample lane of a packed word, from port configuration and direction
  function automatic logic [1:0] ddpf_last_lane(input logic [1:0] c, input logic is_in);
    if (c == DDPF_OUT_32BIT_CONFIG)
      ddpf_last_lane = 2'h0;
    else if (is_in && c == DDPF_IN16_OUT8_CONFIG)
      ddpf_last_lane = 2'h1;
    else
      ddpf_last_lane = 2'h3;
  endfunction

  function automatic logic ddpf_fifo_full(input logic [DDPF_FIFO_AW:0] w, input logic [DDPF_FIFO_AW:0] r);
    ddpf_fifo_full = (w[DDPF_FIFO_AW] != r[DDPF_FIFO_AW]) &&
                     (w[DDPF_FIFO_AW-1:0] == r[DDPF_FIFO_AW-1:0]);
  endfunction

  assign acc       = I_PSEL && I_PENABLE;
  assign wr        = acc && I_PWRITE;
  assign cfg       = ctrl_r[DDPF_C_CFG_LSB +: 2];
  assign in_start  = wr && I_PADDR == DDPF_CTRL_OFS && I_PWDATA[DDPF_C_IN_START];
  assign in_abort  = wr && I_PADDR == DDPF_CTRL_OFS && I_PWDATA[DDPF_C_IN_ABORT];
  assign out_start = wr && I_PADDR == DDPF_CTRL_OFS && I_PWDATA[DDPF_C_OUT_START];
  assign out_abort = wr && I_PADDR == DDPF_CTRL_OFS && I_PWDATA[DDPF_C_OUT_ABORT];
  assign in_full   = ddpf_fifo_full(iw_r, ir_r);
  assign in_empty  = iw_r == ir_r;
  assign out_full  = ddpf_fifo_full(ow_r, or_r);
  assign out_empty = ow_r == or_r;
  assign samp_word = I_DIN;

  ////////////////////////////////////////////////////////////////////////////
  // Pacers: shared 10 MHz base, three divide-by-N counters
  always_comb begin
    base_nxt = (base_r == DDPF_BASE_DIV - 4'h1) ? 4'h0 : base_r + 4'h1;
    for (int k = 0; k < 3; k++) begin
      tick[k]     = 1'b0;
      pcnt_nxt[k] = pcnt_r[k];
      if (base_r == 4'h0) begin
        // Divisor below 2 treated as 2; software keeps it in range
        if (pcnt_r[k] <= 16'h0001) begin
          tick[k]     = 1'b1;
          pcnt_nxt[k] = (div_r[k] < DDPF_DIV_MIN) ? DDPF_DIV_MIN : div_r[k];
        end else begin
          pcnt_nxt[k] = pcnt_r[k] - 16'h0001;
        end
      end
    end
    // Restart on start so the first word is fetched before its first tick
    if (in_start)
      pcnt_nxt[0] = div_r[0];
    if (out_start)
      pcnt_nxt[1] = div_r[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input packing and FIFO push, paced by counter 0
  always_comb begin
    ilane_nxt = ilane_r;
    ipack_nxt = ipack_r;
    in_push   = 1'b0;
    if (samp_r && tick[0]) begin
      unique case (ddpf_last_lane(cfg, 1'b1))
        2'h0: ipack_nxt = samp_word;
        2'h1: ipack_nxt = {samp_word[15:0], ipack_r[31:16]};
        default: ipack_nxt = {samp_word[7:0], ipack_r[31:8]};
      endcase
      if (ilane_r == ddpf_last_lane(cfg, 1'b1)) begin
        ilane_nxt = 2'h0;
        in_push   = 1'b1;
      end else begin
        ilane_nxt = ilane_r + 2'h1;
      end
    end
    if (in_start)
      ilane_nxt = 2'h0;
  end

  // Output unpacking, paced by counter 1
  always_comb begin
    lane_nxt = lane_r;
    dout_nxt = dout_r;
    out_pop  = 1'b0;
    und_nxt  = out_start ? 1'b0 : und_r;
    if (out_busy_r && tick[1]) begin
      if (out_empty) begin
        und_nxt = 1'b1;
      end else begin
        unique case (ddpf_last_lane(cfg, 1'b0))
          2'h0: dout_nxt = ofq_r[or_r[DDPF_FIFO_AW-1:0]];
          default: dout_nxt = {24'h000000, ofq_r[or_r[DDPF_FIFO_AW-1:0]][8*lane_r +: 8]};
        endcase
        if (lane_r == ddpf_last_lane(cfg, 1'b0)) begin
          lane_nxt = 2'h0;
          out_pop  = 1'b1;
        end else begin
          lane_nxt = lane_r + 2'h1;
        end
      end
    end
    if (out_start)
      lane_nxt = 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus master: one access per word, released when idle
  always_comb begin
    st_nxt       = st_r;
    in_addr_nxt  = in_addr_r;
    out_addr_nxt = out_addr_r;
    in_left_nxt  = in_left_r;
    out_left_nxt = out_left_r;
    dcnt_nxt     = dcnt_r;
    dsc_in_nxt   = dsc_in_r;
    dnext_nxt    = dnext_r;
    opush        = 1'b0;
    in_done      = 1'b0;
    out_done     = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        // Descriptor fetch when a chained list needs its next node
        if (in_busy_r && in_left_r == 22'h000000 && ctrl_r[DDPF_C_IN_CHAIN] && in_addr_r != 32'h00000000) begin
          st_nxt = ST_DSCR; dsc_in_nxt = 1'b1; dcnt_nxt = 2'h0;
        end else if (out_busy_r && out_left_r == 22'h000000 && ctrl_r[DDPF_C_OUT_CHAIN] &&
                     out_addr_r != 32'h00000000) begin
          st_nxt = ST_DSCR; dsc_in_nxt = 1'b0; dcnt_nxt = 2'h0;
        end else if (in_busy_r && in_left_r != 22'h000000 && !in_empty)
          st_nxt = ST_IN_WR;
        else if (out_busy_r && out_left_r != 22'h000000 && !out_full)
          st_nxt = ST_OUT_RD;
      end
      ST_IN_WR: if (I_MGNT && I_MACK) begin
        in_addr_nxt = in_addr_r + 32'h00000004;
        in_left_nxt = in_left_r - 22'h000001;
        st_nxt      = ST_IDLE;
        in_done     = in_left_r == 22'h000001 && !ctrl_r[DDPF_C_IN_CHAIN];
        // Drained buffer goes to the saved node; one pointer, so chain one direction at a time
        if (in_left_r == 22'h000001 && ctrl_r[DDPF_C_IN_CHAIN])
          in_addr_nxt = dnext_r;
      end
      ST_OUT_RD: if (I_MGNT && I_MACK) begin
        opush        = 1'b1;
        out_addr_nxt = out_addr_r + 32'h00000004;
        out_left_nxt = out_left_r - 22'h000001;
        st_nxt       = ST_IDLE;
        if (out_left_r == 22'h000001 && ctrl_r[DDPF_C_OUT_CHAIN])
          out_addr_nxt = dnext_r;
        else if (out_left_r == 22'h000001 && ctrl_r[DDPF_C_PATTERN]) begin
          out_addr_nxt = out_base_r;  // Replay from start
          out_left_nxt = out_cnt_r;
        end
      end
      ST_DSCR: if (I_MGNT && I_MACK) begin
        // Node: word0 buffer address, word1 length, word2 next node (0 ends)
        dcnt_nxt = dcnt_r + 2'h1;
        if (dcnt_r == 2'h0) dnext_nxt = I_MRDATA;
        if (dcnt_r == 2'h1) begin
          if (dsc_in_r) in_left_nxt = I_MRDATA[21:0];
          else out_left_nxt = I_MRDATA[21:0];
        end
        if (dcnt_r == 2'h2) begin
          st_nxt    = ST_IDLE;
          dnext_nxt = I_MRDATA;
          // An empty node goes straight on to the next node
          if (dsc_in_r)
            in_addr_nxt = (in_left_nxt == 22'h000000) ? I_MRDATA : dnext_r;
          else
            out_addr_nxt = (out_left_nxt == 22'h000000) ? I_MRDATA : dnext_r;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    // Chain end: a drained buffer with next node 0 completes chained input
    if (st_r == ST_IDLE && in_busy_r && ctrl_r[DDPF_C_IN_CHAIN] && in_left_r == 22'h000000 &&
        in_addr_r == 32'h00000000)
      in_done = 1'b1;
    // Output ends only after the last word has left the FIFO
    if (st_r == ST_IDLE && out_busy_r && out_left_r == 22'h000000 && out_empty &&
        (!ctrl_r[DDPF_C_OUT_CHAIN] || out_addr_r == 32'h00000000))
      out_done = 1'b1;
    if (in_start) begin
      in_addr_nxt = in_addr_r; in_left_nxt = ctrl_r[DDPF_C_IN_CHAIN] ? 22'h000000 : in_cnt_r;
    end
    if (out_start) begin
      out_left_nxt = ctrl_r[DDPF_C_OUT_CHAIN] ? 22'h000000 : out_cnt_r;
    end
    if (in_abort || out_abort || in_start || out_start)
      st_nxt = ST_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Busy, sampling and sticky flags
  always_comb begin
    in_busy_nxt  = in_busy_r;
    out_busy_nxt = out_busy_r;
    samp_nxt     = samp_r;
    // A late event beats the clear of a start in the same cycle
    ovr_nxt      = in_start ? 1'b0 : ovr_r;
    if (in_push && in_full)
      ovr_nxt = 1'b1;
    if (in_done) begin
      in_busy_nxt = 1'b0;
      if (ctrl_r[DDPF_C_STOP_OPT]) samp_nxt = 1'b0;
    end
    if (out_done) out_busy_nxt = 1'b0;
    if (in_abort) begin in_busy_nxt = 1'b0; samp_nxt = 1'b0; end
    if (out_abort) out_busy_nxt = 1'b0;
    if (in_start) begin in_busy_nxt = 1'b1; samp_nxt = 1'b1; end
    if (out_start) out_busy_nxt = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFO pointers
  always_comb begin
    iw_nxt = iw_r + (DDPF_FIFO_AW+1)'(in_push && !in_full);
    ir_nxt = ir_r + (DDPF_FIFO_AW+1)'(st_r == ST_IN_WR && I_MGNT && I_MACK);
    ow_nxt = ow_r + (DDPF_FIFO_AW+1)'(opush);
    or_nxt = or_r + (DDPF_FIFO_AW+1)'(out_pop);
    if (in_start && I_PWDATA[DDPF_C_CLR_FIFO]) begin
      iw_nxt = '0; ir_nxt = '0;
    end
    if (out_start || out_abort) begin
      ow_nxt = '0; or_nxt = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB registers
  always_comb begin
    ctrl_nxt     = ctrl_r & ~32'h0000000F;
    div_nxt      = div_r;
    out_base_nxt = out_base_r;
    prdata_nxt   = 32'h00000000;
    if (wr) begin
      unique case (I_PADDR)
        DDPF_CTRL_OFS:     ctrl_nxt = {21'h000000, I_PWDATA[10:4], 4'h0};
        DDPF_IN_DIV_OFS:   div_nxt[0] = I_PWDATA[15:0];
        DDPF_OUT_DIV_OFS:  div_nxt[1] = I_PWDATA[15:0];
        DDPF_AUX_DIV_OFS:  div_nxt[2] = I_PWDATA[15:0];
        default: ;
      endcase
    end
    if (out_start) out_base_nxt = out_addr_r;
    unique case (I_PADDR)
      DDPF_CTRL_OFS:     prdata_nxt = ctrl_r;
      DDPF_STAT_OFS:     prdata_nxt = {27'h0000000, samp_r, und_r, ovr_r, out_busy_r, in_busy_r};
      DDPF_IN_DIV_OFS:   prdata_nxt = {16'h0000, div_r[0]};
      DDPF_OUT_DIV_OFS:  prdata_nxt = {16'h0000, div_r[1]};
      DDPF_AUX_DIV_OFS:  prdata_nxt = {16'h0000, div_r[2]};
      DDPF_IN_ADDR_OFS:  prdata_nxt = in_addr_r;
      DDPF_IN_CNT_OFS:   prdata_nxt = {10'h000, in_cnt_r};
      DDPF_OUT_ADDR_OFS: prdata_nxt = out_addr_r;
      DDPF_OUT_CNT_OFS:  prdata_nxt = {10'h000, out_cnt_r};
      DDPF_IN_LEFT_OFS:  prdata_nxt = {10'h000, in_left_r};
      DDPF_OUT_LEFT_OFS: prdata_nxt = {10'h000, out_left_r};
      default:           prdata_nxt = 32'h00000000;
    endcase
  end

  // Address and count registers share one write path
  logic [31:0] ia_w, oa_w;
  logic [21:0] ic_w, oc_w;
  always_comb begin
    ia_w = (wr && I_PADDR == DDPF_IN_ADDR_OFS) ? I_PWDATA : in_addr_nxt;
    oa_w = (wr && I_PADDR == DDPF_OUT_ADDR_OFS) ? I_PWDATA : out_addr_nxt;
    // Counts above 2^21 clamp to the limit
    ic_w = (wr && I_PADDR == DDPF_IN_CNT_OFS) ?
           ((I_PWDATA > 32'(DDPF_CNT_MAX)) ? DDPF_CNT_MAX : I_PWDATA[21:0]) : in_cnt_r;
    oc_w = (wr && I_PADDR == DDPF_OUT_CNT_OFS) ?
           ((I_PWDATA > 32'(DDPF_CNT_MAX)) ? DDPF_CNT_MAX : I_PWDATA[21:0]) : out_cnt_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_r <= 32'h00000000; base_r <= 4'h0; st_r <= ST_IDLE;
      for (int k = 0; k < 3; k++) begin
        div_r[k] <= DDPF_DIV_RST; pcnt_r[k] <= DDPF_DIV_RST;
      end
      in_addr_r <= 32'h00000000; out_addr_r <= 32'h00000000; out_base_r <= 32'h00000000;
      in_cnt_r <= 22'h000000; out_cnt_r <= 22'h000000;
      in_left_r <= 22'h000000; out_left_r <= 22'h000000;
      in_busy_r <= 1'b0; out_busy_r <= 1'b0; samp_r <= 1'b0; ovr_r <= 1'b0; und_r <= 1'b0;
      iw_r <= '0; ir_r <= '0; ow_r <= '0; or_r <= '0;
      dout_r <= 32'h00000000; lane_r <= 2'h0; ilane_r <= 2'h0; ipack_r <= 32'h00000000;
      dcnt_r <= 2'h0; dsc_in_r <= 1'b0; dnext_r <= 32'h00000000; O_PRDATA <= 32'h00000000;
    end else begin
      ctrl_r <= ctrl_nxt; base_r <= base_nxt; st_r <= st_nxt;
      div_r <= div_nxt; pcnt_r <= pcnt_nxt;
      in_addr_r <= ia_w; out_addr_r <= oa_w; out_base_r <= out_base_nxt;
      in_cnt_r <= ic_w; out_cnt_r <= oc_w;
      in_left_r <= in_left_nxt; out_left_r <= out_left_nxt;
      in_busy_r <= in_busy_nxt; out_busy_r <= out_busy_nxt; samp_r <= samp_nxt;
      ovr_r <= ovr_nxt; und_r <= und_nxt;
      iw_r <= iw_nxt; ir_r <= ir_nxt; ow_r <= ow_nxt; or_r <= or_nxt;
      dout_r <= dout_nxt; lane_r <= lane_nxt; ilane_r <= ilane_nxt; ipack_r <= ipack_nxt;
      dcnt_r <= dcnt_nxt; dsc_in_r <= dsc_in_nxt; dnext_r <= dnext_nxt; O_PRDATA <= prdata_nxt;
    end
  end

  // FIFO storage needs no reset
  always_ff @(posedge I_MCLK) begin
    if (in_push && !in_full) ifq_r[iw_r[DDPF_FIFO_AW-1:0]] <= ipack_nxt;
    if (opush) ofq_r[ow_r[DDPF_FIFO_AW-1:0]] <= I_MRDATA;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign O_PREADY   = 1'b1;
  assign O_PSLVERR  = 1'b0;
  assign O_MREQ     = st_r != ST_IDLE;
  assign O_MADDR    = (st_r == ST_IN_WR) ? in_addr_r : (st_r == ST_DSCR) ?
                      ((dsc_in_r ? in_addr_r : out_addr_r) + {28'h0000000, dcnt_r, 2'h0}) : out_addr_r;
  assign O_MWRITE   = st_r == ST_IN_WR;
  assign O_MWDATA   = ifq_r[ir_r[DDPF_FIFO_AW-1:0]];
  assign O_DOUT     = dout_r;
  assign O_AUX_TICK = tick[2];
endmodule

// file: verif/ddpf_properties.sv
// Checker: port-level properties of the DIO DMA pacer block
`timescale 1ns/10ps
module ddpf_properties
  import ddpf_pkg::*;
(
  input wire logic        I_MCLK,
  input wire logic        I_RST_B,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [7:0]  I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic        O_MREQ,
  input wire logic        I_MGNT,
  input wire logic        I_MACK,
  input wire logic [31:0] O_MADDR,
  input wire logic        O_MWRITE,
  input wire logic [31:0] O_MWDATA,
  input wire logic        O_AUX_TICK
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_B);
  logic pend;
  logic rd_setup;
  // A request still open: issued but not yet granted and acknowledged
  logic ctl_cmd;
  // Start and abort may drop an open request at once
  assign ctl_cmd = I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == DDPF_CTRL_OFS && |I_PWDATA[3:0];
  assign pend = O_MREQ && !(I_MGNT && I_MACK) && !ctl_cmd;
  assign rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;
  ////////////////////////////////////////////////////////////////////////////////
  a_ready_zero_wait: assert property (I_PSEL && I_PENABLE |-> O_PREADY && !O_PSLVERR)
    else $error("register access not answered at once");
  a_mreq_held: assert property (pend |=> O_MREQ)
    else $error("bus request dropped before acknowledge");
  a_maddr_held: assert property (pend |=> $stable(O_MADDR) && $stable(O_MWRITE))
    else $error("bus address or direction moved while pending");
  a_mwdata_held: assert property (pend && O_MWRITE |=> $stable(O_MWDATA))
    else $error("bus write data moved while pending");
  a_maddr_aligned: assert property (O_MREQ |-> O_MADDR[1:0] == 2'h0)
    else $error("bus address not on a double-word");
  a_aux_tick_gap: assert property (O_AUX_TICK |=> !O_AUX_TICK [*3])
    else $error("aux pacer ticks closer than divisor two");
  a_unmapped_zero: assert property (rd_setup && I_PADDR >= 8'h2C |=> O_PRDATA == 32'h0)
    else $error("unmapped read returned nonzero");
  a_stat_upper_zero: assert property (rd_setup && I_PADDR == DDPF_STAT_OFS |=> O_PRDATA[31:5] == 27'h0)
    else $error("status unused bits nonzero");
  c_mem_write: cover property (O_MREQ && I_MGNT && I_MACK && O_MWRITE);
  c_mem_read: cover property (O_MREQ && I_MGNT && I_MACK && !O_MWRITE);
  c_aux_tick: cover property (O_AUX_TICK);
endmodule

// file: verif/ddpf_mem_model.sv
// Host memory and bus arbiter model facing the DMA master port
`timescale 1ns/10ps
module ddpf_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_stall,
  input  wire logic        i_req,
  input  wire logic [31:0] i_addr,
  input  wire logic        i_write,
  input  wire logic [31:0] i_wdata,
  output logic             o_gnt,
  output logic             o_ack,
  output logic      [31:0] o_rdata
);
  logic [31:0] mem [0:63];
  logic [1:0]  wait_r;
  // Plain always: the bench preloads mem hierarchically
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_gnt <= 1'b0;
      o_ack <= 1'b0;
      wait_r <= 2'h0;
      o_rdata <= 32'h0;
    end else begin
      o_gnt <= i_req && !i_stall;
      o_ack <= 1'b0;
      // Stale read data is inverted every cycle, so a sample one cycle late shows
      o_rdata <= ~o_rdata;
      if (o_ack && o_gnt && i_req && i_write) begin
        mem[i_addr[7:2]] <= i_wdata;
      end
      if (o_gnt && i_req && !o_ack && !i_stall) begin
        wait_r <= wait_r + 2'h1;
        if (wait_r == 2'h1) begin
          o_ack <= 1'b1;
          wait_r <= 2'h0;
          o_rdata <= mem[i_addr[7:2]];
        end
      end
    end
  end
endmodule

// file: verif/tb.sv
// Testbench: register-driven DMA, pacer and flag scenarios
`timescale 1ns/10ps
module tb;
  import ddpf_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, stall = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, din = 32'h0, prdata, maddr, mwdata, mrdata, dout, last = 32'h0;
  logic pready, pslverr, mreq, mgnt, mwrite, mack, aux;
  int cyc = 0, fail_count = 0, cmp_count = 0, k, n, t0;
  logic [31:0] dq[$];
  int tq[$];
  ddpf_top dut (.I_MCLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_MREQ(mreq), .I_MGNT(mgnt), .O_MADDR(maddr), .O_MWRITE(mwrite), .O_MWDATA(mwdata),
    .I_MRDATA(mrdata), .I_MACK(mack), .I_DIN(din), .O_DOUT(dout), .O_AUX_TICK(aux));
  ddpf_mem_model u_mem (.i_clk(clk), .i_rst_b(rst_b), .i_stall(stall), .i_req(mreq), .i_addr(maddr),
    .i_write(mwrite), .i_wdata(mwdata), .o_gnt(mgnt), .o_ack(mack), .o_rdata(mrdata));
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Input word carries its own sample time
  always @(posedge clk) begin
    cyc <= cyc + 1;
    din <= 32'(cyc + 1);
    if (dout !== last) begin
      dq.push_back(dout);
      tq.push_back(cyc);
      last = dout;
    end
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Idle cycle after each access keeps one assignment per time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic wait_clear(input int b);
    logic [31:0] q;
    q = '1;
    for (int i = 0; i < 300 && q[b] !== 1'b0; i++) apb(1'b0, DDPF_STAT_OFS, 32'h0, q);
    chk({31'h0, q[b]}, 32'h0);
  endtask
  task automatic tick_gap(output int c);
    c = 0;
    do begin @(posedge clk); c++; end while (aux !== 1'b1 && c < 400);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 3; k++) rd_chk(8'(DDPF_IN_DIV_OFS + 4 * k), 32'hFFFF, {16'h0, DDPF_DIV_RST});
    wr(8'h2C, 32'hFFFFFFFF);
    rd_chk(8'h2C, 32'hFFFFFFFF, 32'h0);
    rd_chk(DDPF_STAT_OFS, 32'h1F, 32'h0);
    wr(DDPF_AUX_DIV_OFS, 32'h3);
    tick_gap(n);
    tick_gap(n);
    tick_gap(n);
    chk(32'(n), 32'h6);
    $display("test registers and aux pacer done");
    u_mem.mem[22] = 32'hDEADBEEF;
    wr(DDPF_IN_DIV_OFS, 32'h5);
    wr(DDPF_IN_ADDR_OFS, 32'h40);
    wr(DDPF_IN_CNT_OFS, 32'h6);
    wr(DDPF_CTRL_OFS, 32'h0);
    wr(DDPF_CTRL_OFS, 32'h1);
    wait_clear(DDPF_S_IN_BUSY);
    for (k = 0; k < 5; k++) chk(u_mem.mem[17 + k] - u_mem.mem[16 + k], 32'hA);
    chk(u_mem.mem[22], 32'hDEADBEEF);
    rd_chk(DDPF_IN_LEFT_OFS, 32'hFFFFFFFF, 32'h0);
    $display("test input dma done");
    for (k = 0; k < 4; k++) u_mem.mem[32 + k] = 32'hA5000000 + 32'(k);
    dq.delete();
    tq.delete();
    wr(DDPF_OUT_DIV_OFS, 32'h14);
    wr(DDPF_OUT_ADDR_OFS, 32'h80);
    wr(DDPF_OUT_CNT_OFS, 32'h4);
    wr(DDPF_CTRL_OFS, 32'h0);
    wr(DDPF_CTRL_OFS, 32'h4);
    rd_chk(DDPF_STAT_OFS, 32'h2, 32'h2);
    wait_clear(DDPF_S_OUT_BUSY);
    chk(32'(dq.size()), 32'h4);
    for (k = 0; k < 4; k++) chk(dq[k], 32'hA5000000 + 32'(k));
    for (k = 1; k < 4; k++) chk(32'(tq[k] - tq[k - 1]), 32'h28);
    rd_chk(DDPF_STAT_OFS, 32'h8, 32'h0);
    $display("test output dma done");
    stall <= 1'b1;
    wr(DDPF_IN_DIV_OFS, 32'h2);
    wr(DDPF_IN_CNT_OFS, 32'h64);
    wr(DDPF_CTRL_OFS, 32'h0);
    wr(DDPF_CTRL_OFS, 32'h1);
    repeat (150) @(posedge clk);
    chk({31'h0, mreq}, 32'h1);
    rd_chk(DDPF_STAT_OFS, 32'h5, 32'h5);
    wr(DDPF_CTRL_OFS, 32'h2);
    rd_chk(DDPF_STAT_OFS, 32'h5, 32'h4);
    chk({31'h0, mreq}, 32'h0);
    stall <= 1'b0;
    t0 = cyc;
    wr(DDPF_IN_DIV_OFS, 32'h5);
    wr(DDPF_IN_ADDR_OFS, 32'h40);
    wr(DDPF_IN_CNT_OFS, 32'h2);
    wr(DDPF_CTRL_OFS, 32'h30);
    wr(DDPF_CTRL_OFS, 32'h31);
    wait_clear(DDPF_S_IN_BUSY);
    rd_chk(DDPF_STAT_OFS, 32'h14, 32'h0);
    chk({31'h0, u_mem.mem[16] > 32'(t0)}, 32'h1);
    $display("test overrun and abort done");
    stall <= 1'b1;
    wr(DDPF_OUT_DIV_OFS, 32'h2);
    wr(DDPF_OUT_ADDR_OFS, 32'h80);
    wr(DDPF_OUT_CNT_OFS, 32'h4);
    wr(DDPF_CTRL_OFS, 32'h0);
    wr(DDPF_CTRL_OFS, 32'h4);
    repeat (60) @(posedge clk);
    rd_chk(DDPF_STAT_OFS, 32'hA, 32'hA);
    wr(DDPF_CTRL_OFS, 32'h8);
    rd_chk(DDPF_STAT_OFS, 32'hA, 32'h8);
    stall <= 1'b0;
    wr(DDPF_OUT_CNT_OFS, 32'h2);
    wr(DDPF_OUT_ADDR_OFS, 32'h80);
    dq.delete();
    wr(DDPF_CTRL_OFS, 32'h500);
    wr(DDPF_CTRL_OFS, 32'h504);
    repeat (100) @(posedge clk);
    rd_chk(DDPF_STAT_OFS, 32'h2, 32'h2);
    chk(dq[1], 32'hA5);
    chk(dq[2], 32'h1);
    chk(dq[7], 32'h1);
    wr(DDPF_CTRL_OFS, 32'h8);
    rd_chk(DDPF_STAT_OFS, 32'h2, 32'h0);
    $display("test underrun and pattern done");
    finish_test();
  end
endmodule
bind ddpf_top ddpf_properties u_props (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_PSEL(I_PSEL), .I_PWDATA(I_PWDATA),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .O_MREQ(O_MREQ), .I_MGNT(I_MGNT), .I_MACK(I_MACK), .O_MADDR(O_MADDR),
  .O_MWRITE(O_MWRITE), .O_MWDATA(O_MWDATA), .O_AUX_TICK(O_AUX_TICK));
